//--- logic/pci_front_pkg.sv
// shared constants for the pci parity and config loader front end
// assumes one pci clock domain, active-low async reset
package pci_front_pkg;
  localparam int          CFG_BYTES      = 64;
  localparam int          CFG_WORDS      = 16;
  localparam logic [3:0]  CMD_INT_ACK    = 4'h0;
  localparam logic [3:0]  CMD_SPECIAL    = 4'h1;
  localparam logic [3:0]  CMD_IO_READ    = 4'h2;
  localparam logic [3:0]  CMD_IO_WRITE   = 4'h3;
  localparam logic [3:0]  CMD_MEM_READ   = 4'h6;
  localparam logic [3:0]  CMD_MEM_WRITE  = 4'h7;
  localparam logic [3:0]  CMD_CFG_READ   = 4'ha;
  localparam logic [3:0]  CMD_CFG_WRITE  = 4'hb;
  // three-wire eeprom read opcode: start bit then 2'b10
  localparam logic [2:0]  EE_OP_READ     = 3'h6;
  localparam int          EE_OP_BITS     = 3;
  localparam int          EE_ADDR_BITS   = 6;
  localparam int          EE_DATA_BITS   = 16;
  localparam int          EE_SHIFT_BITS  = 9;
  // eeprom serial clock half period minus one, in pci clocks (tick every 8)
  localparam logic [3:0]  EE_HALF_PERIOD = 4'h7;
  localparam logic [1:0]  ADDR_CFG_TYPE0 = 2'h0;
  localparam int          CFG_REG_LSB    = 2;
  localparam int          CFG_REG_MSB    = 5;
  // default config word used when the eeprom is disabled
  localparam logic [31:0] DEFAULT_ID     = 32'h12345678; // arbitrary value
  localparam logic [31:0] DEFAULT_CLASS  = 32'h07000000;
  localparam logic [31:0] DEFAULT_ZERO   = 32'h00000000;
  localparam int          IDX_ID         = 0;
  localparam int          IDX_CLASS      = 2;
  localparam int          IDX_INT_PIN    = 15;
  localparam logic [31:0] DEFAULT_INTPIN = 32'h00000100;
endpackage

//--- logic/eeprom_reader.sv
// serial eeprom word reader, one 16-bit word per request
// assumes a three-wire microwire style memory, msb first
`timescale 1ns/1ns
module eeprom_reader
  import pci_front_pkg::*;
(
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_clk_en,
  // request side
  input  wire logic                    i_start,
  input  wire logic [EE_ADDR_BITS-1:0] i_addr,
  output logic                         o_busy,
  output logic                         o_done,
  output logic [EE_DATA_BITS-1:0]      o_data,
  // eeprom pins
  output logic                         o_eeprom_select,
  output logic                         o_eeprom_serial_clock,
  output logic                         o_eeprom_serial_out,
  input  wire logic                    i_eeprom_serial_in
);
  typedef enum logic [1:0] {IDLE, SEND, RECV, FIN} ee_state_t;
  ee_state_t                ee_state_q;
  logic [3:0]               div_q;
  logic [4:0]               bit_q;
  logic [EE_SHIFT_BITS-1:0] cmd_q;
  logic                     tick;

  assign tick   = (div_q == EE_HALF_PERIOD);
  assign o_busy = (ee_state_q != IDLE);

  // half-period divider, keeps the memory clock well under its limit
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 4'h0;
    end else if (i_clk_en) begin
      div_q <= (tick || ee_state_q == IDLE) ? 4'h0 : div_q + 4'h1;
    end
  end

  // command shift then data capture on rising serial clock R16
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ee_state_q            <= IDLE;
      bit_q                 <= 5'h00;
      cmd_q                 <= '0;
      o_data                <= '0;
      o_done                <= 1'b0;
      o_eeprom_select       <= 1'b0;
      o_eeprom_serial_clock <= 1'b0;
      o_eeprom_serial_out   <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      case (ee_state_q)
        IDLE: begin
          if (i_start) begin
            // start bit set up before the first rising serial clock
            cmd_q               <= {EE_OP_READ, i_addr} << 1;
            bit_q               <= 5'(EE_SHIFT_BITS - 1);
            o_eeprom_serial_out <= EE_OP_READ[EE_OP_BITS-1];
            o_eeprom_select     <= 1'b1; // R11
            ee_state_q      <= SEND;
          end
        end
        SEND: begin
          if (tick) begin
            o_eeprom_serial_clock <= ~o_eeprom_serial_clock; // R11
            if (!o_eeprom_serial_clock) begin
              if (bit_q == 5'h00) begin
                bit_q      <= 5'(EE_DATA_BITS);
                ee_state_q <= RECV;
              end
            end else begin
              o_eeprom_serial_out <= cmd_q[EE_SHIFT_BITS-1];
              cmd_q               <= {cmd_q[EE_SHIFT_BITS-2:0], 1'b0};
              bit_q               <= bit_q - 5'h01;
            end
          end
        end
        RECV: begin
          if (tick) begin
            o_eeprom_serial_clock <= ~o_eeprom_serial_clock;
            o_eeprom_serial_out   <= 1'b0;
            if (!o_eeprom_serial_clock) begin
              o_data <= {o_data[EE_DATA_BITS-2:0], i_eeprom_serial_in};
              bit_q  <= bit_q - 5'h01;
              if (bit_q == 5'h01) begin
                ee_state_q <= FIN;
              end
            end
          end
        end
        FIN: begin
          if (tick) begin
            o_eeprom_serial_clock <= 1'b0;
            o_eeprom_select       <= 1'b0;
            o_done                <= 1'b1;
            ee_state_q            <= IDLE;
          end
        end
        default: ee_state_q <= IDLE;
      endcase
    end
  end
endmodule

//--- logic/pci_parity_cfg_loader.sv
// pci target front end: parity check/generate, config load from eeprom
// assumes pci signals synchronous to i_ref_clk, host keeps pci protocol
//
// Overview of operation
// R1 - data parity errors on perr, not special
// R2 - perr held low at least one clock
// R3 - address parity error pulls serr low; the code checks address parity only on address phases with idsel high
// R4 - even parity over ad and cbe
// R5 - initiator gives address parity next clock
// R6 - data parity one clock after irdy/trdy
// R7 - cbe decoded as command in address phase
// R8 - cbe bit n enables byte lane n
// R9 - inta low while enabled interrupt pending
// R10 - load 64 config bytes from eeprom in order
// R11 - drive select, clock, data out, sample data in
// R12 - eeprom enable is active high, pulled up
// R13 - enable low loads built-in defaults
// R14 - reset returns all state, floats ad and serr; cfg_mem has no reset, the loader rewrites it
// R15 - config cycles accepted only with idsel
// R16 - conventional three-wire read command sequence
// R17 - retry config reads until load done
`timescale 1ns/1ns
module pci_parity_cfg_loader
  import pci_front_pkg::*;
(
  // clock, reset, enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // pci bus inputs
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_idsel,
  input  wire logic [31:0] i_ad,
  input  wire logic [3:0]  i_cbe_n,
  input  wire logic        i_par,
  // pci bus outputs with enables
  output logic [31:0]      o_ad,
  output logic             o_ad_oe,
  output logic             o_par,
  output logic             o_par_oe,
  output logic             o_trdy_n,
  output logic             o_stop_n,
  output logic             o_devsel_n,
  output logic             o_target_oe,
  output logic             o_perr_n,
  output logic             o_perr_oe,
  output logic             o_serr_oe,
  output logic             o_inta_oe,
  // interrupt sources from the uart and printer side
  input  wire logic        i_irq_pending,
  input  wire logic        i_irq_enable,
  // config write data toward the function registers
  output logic             o_cfg_wr,
  output logic [3:0]       o_cfg_wr_idx,
  output logic [31:0]      o_cfg_wr_data,
  output logic [3:0]       o_cfg_wr_be,
  output logic             o_load_done,
  // eeprom pins
  input  wire logic        i_eeprom_use_enable,
  output logic             o_eeprom_select,
  output logic             o_eeprom_serial_clock,
  output logic             o_eeprom_serial_out,
  input  wire logic        i_eeprom_serial_in
);
  typedef enum logic [2:0] {T_IDLE, T_DATA, T_TURN, T_RETRY, T_WAIT}
    tgt_state_t;
  typedef enum logic [1:0] {L_START, L_ISSUE, L_WAIT, L_DONE} ld_state_t;

  // even parity over ad and cbe
  function automatic logic even_par(input logic [31:0] ad,
                                    input logic [3:0] cbe);
    even_par = ^{ad, cbe}; // R4
  endfunction

  // merge byte lanes under active-low enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be_n);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = be_n[i] ? old_w[i*8 +: 8] : new_w[i*8 +: 8];
    end
  endfunction

  tgt_state_t   tgt_q;
  ld_state_t    ld_q;
  logic [31:0]  cfg_mem [CFG_WORDS];
  logic [3:0]   cmd_q;
  logic [3:0]   idx_q;
  logic         is_read_q;
  logic         addr_chk_q;
  logic [31:0]  addr_ad_q;
  logic [3:0]   addr_cbe_q;
  logic         wr_chk_q;
  logic [31:0]  wr_ad_q;
  logic [3:0]   wr_cbe_q;
  logic         frame_n_q;
  logic         perr_hold_q;
  logic [4:0]   word_q;
  logic         ee_start;
  logic         ee_done;
  logic [15:0]  ee_data;
  logic         hi_half_q;
  logic         addr_phase;
  logic         cfg_hit;
  logic         data_xfer;
  logic [3:0]   cmd_now;

  assign addr_phase = (tgt_q == T_IDLE) && frame_n_q && !i_frame_n;
  assign cmd_now    = i_cbe_n; // R7
  assign cfg_hit    = addr_phase && i_idsel && // R15
                      (i_ad[1:0] == ADDR_CFG_TYPE0) &&
                      (cmd_now == CMD_CFG_READ || cmd_now == CMD_CFG_WRITE);
  assign data_xfer  = (tgt_q == T_DATA) && !i_irdy_n && !o_trdy_n;

  // target sequencer: single data phase, disconnect with data
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tgt_q       <= T_IDLE; // R14
      cmd_q       <= 4'h0;
      idx_q       <= 4'h0;
      is_read_q   <= 1'b0;
      o_trdy_n    <= 1'b1;
      o_stop_n    <= 1'b1;
      o_devsel_n  <= 1'b1;
      o_target_oe <= 1'b0;
      o_ad_oe     <= 1'b0;
    end else if (i_clk_en) begin
      case (tgt_q)
        T_IDLE: begin
          if (cfg_hit) begin
            cmd_q       <= cmd_now; // R7
            idx_q       <= i_ad[CFG_REG_MSB:CFG_REG_LSB];
            is_read_q   <= (cmd_now == CMD_CFG_READ);
            o_devsel_n  <= 1'b0;
            o_target_oe <= 1'b1;
            if (!o_load_done) begin
              // no data until the loader finished
              o_stop_n <= 1'b0; // R17
              tgt_q    <= T_RETRY;
            end else begin
              o_trdy_n <= 1'b0;
              o_stop_n <= 1'b0;
              o_ad_oe  <= (cmd_now == CMD_CFG_READ);
              tgt_q    <= T_DATA;
            end
          end
        end
        T_DATA: begin
          if (data_xfer) begin
            o_trdy_n   <= 1'b1;
            o_devsel_n <= 1'b1;
            o_stop_n   <= i_frame_n;
            o_ad_oe    <= 1'b0;
            tgt_q      <= i_frame_n ? T_TURN : T_WAIT;
          end
        end
        T_RETRY: begin
          if (!i_irdy_n) begin
            o_devsel_n <= 1'b1;
            o_stop_n   <= i_frame_n;
            tgt_q      <= i_frame_n ? T_TURN : T_WAIT;
          end
        end
        T_WAIT: begin
          // stop stays low until the initiator drops frame
          if (i_frame_n) begin
            o_stop_n <= 1'b1;
            tgt_q    <= T_TURN;
          end
        end
        T_TURN: begin
          o_target_oe <= 1'b0;
          o_stop_n    <= 1'b1;
          tgt_q       <= T_IDLE;
        end
        default: tgt_q <= T_IDLE;
      endcase
    end
  end

  // read data alongside trdy, its parity one clock behind
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ad     <= 32'h00000000;
      o_par    <= 1'b0;
      o_par_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_ad     <= cfg_mem[cfg_hit ? i_ad[CFG_REG_MSB:CFG_REG_LSB] : idx_q];
      o_par    <= even_par(o_ad, i_cbe_n); // R6
      o_par_oe <= o_ad_oe; // R6
    end
  end

  // capture address and write data for checking next clock
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_n_q  <= 1'b1;
      addr_chk_q <= 1'b0;
      addr_ad_q  <= 32'h00000000;
      addr_cbe_q <= 4'h0;
      wr_chk_q   <= 1'b0;
      wr_ad_q    <= 32'h00000000;
      wr_cbe_q   <= 4'h0;
    end else if (i_clk_en) begin
      frame_n_q  <= i_frame_n; // burst data phases are not addresses
      addr_chk_q <= addr_phase && i_idsel; // R5
      addr_ad_q  <= i_ad;
      addr_cbe_q <= i_cbe_n;
      // check every write data phase we claimed, special cycles excluded
      wr_chk_q   <= data_xfer && !is_read_q &&
                    (cmd_q != CMD_SPECIAL); // R1
      wr_ad_q    <= i_ad;
      wr_cbe_q   <= i_cbe_n;
    end
  end

  // perr and serr drive, perr held two clocks for a full low period
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_perr_n    <= 1'b1;
      o_perr_oe   <= 1'b0;
      perr_hold_q <= 1'b0;
      o_serr_oe   <= 1'b0; // R14
    end else if (i_clk_en) begin
      if (wr_chk_q && (even_par(wr_ad_q, wr_cbe_q) != i_par)) begin
        o_perr_n    <= 1'b0; // R1
        o_perr_oe   <= 1'b1;
        perr_hold_q <= 1'b1; // R2
      end else if (perr_hold_q) begin
        perr_hold_q <= 1'b0;
      end else begin
        o_perr_n  <= 1'b1;
        o_perr_oe <= !o_perr_n; // drive high one clock before release
      end
      o_serr_oe <= addr_chk_q &&
                   (even_par(addr_ad_q, addr_cbe_q) != i_par); // R3
    end
  end

  // open-drain interrupt, no latch so it follows the source
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_inta_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_inta_oe <= i_irq_pending && i_irq_enable; // R9
    end
  end

  // config write strobe with byte enables toward the function
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cfg_wr      <= 1'b0;
      o_cfg_wr_idx  <= 4'h0;
      o_cfg_wr_data <= 32'h00000000;
      o_cfg_wr_be   <= 4'h0;
    end else if (i_clk_en) begin
      o_cfg_wr      <= data_xfer && !is_read_q;
      o_cfg_wr_idx  <= idx_q;
      o_cfg_wr_data <= i_ad;
      o_cfg_wr_be   <= ~i_cbe_n; // R8
    end
  end

  // loader: eeprom words, two per config dword, low half first
  assign ee_start = (ld_q == L_ISSUE);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ld_q        <= L_START; // R14
      word_q      <= 5'h00;
      hi_half_q   <= 1'b0;
      o_load_done <= 1'b0;
    end else if (i_clk_en) begin
      case (ld_q)
        L_START: begin
          // strap taken after reset release
          ld_q     <= i_eeprom_use_enable ? L_ISSUE : L_DONE; // R12 R13
        end
        L_ISSUE: ld_q <= L_WAIT;
        L_WAIT: begin
          if (ee_done) begin
            hi_half_q <= ~hi_half_q;
            if (hi_half_q) begin
              word_q <= word_q + 5'h01; // R10
            end
            ld_q <= (hi_half_q && word_q == 5'(CFG_WORDS - 1)) ?
                    L_DONE : L_ISSUE;
          end
        end
        L_DONE: o_load_done <= 1'b1;
        default: ld_q <= L_DONE;
      endcase
    end
  end

  // config image: defaults, or filled from the eeprom
  always_ff @(posedge i_ref_clk) begin
    if (i_clk_en) begin
      if (ld_q == L_START && !i_eeprom_use_enable) begin
        for (int i = 0; i < CFG_WORDS; i++) begin
          cfg_mem[i] <= DEFAULT_ZERO; // R13
        end
        cfg_mem[IDX_ID]      <= DEFAULT_ID;
        cfg_mem[IDX_CLASS]   <= DEFAULT_CLASS;
        cfg_mem[IDX_INT_PIN] <= DEFAULT_INTPIN;
      end else if (ld_q == L_WAIT && ee_done) begin
        if (hi_half_q) begin
          cfg_mem[word_q[3:0]][31:16] <= ee_data; // R10
        end else begin
          cfg_mem[word_q[3:0]][15:0] <= ee_data;
        end
      end else if (o_cfg_wr && o_load_done) begin
        cfg_mem[o_cfg_wr_idx] <= lane_merge(cfg_mem[o_cfg_wr_idx],
                                            o_cfg_wr_data,
                                            ~o_cfg_wr_be); // R8
      end
    end
  end

  eeprom_reader u_reader (
    .i_ref_clk             (i_ref_clk),
    .i_rst_n               (i_rst_n),
    .i_clk_en              (i_clk_en),
    .i_start               (ee_start),
    .i_addr                ({1'b0, word_q[3:0], hi_half_q}),
    .o_busy                (),
    .o_done                (ee_done),
    .o_data                (ee_data),
    .o_eeprom_select       (o_eeprom_select),
    .o_eeprom_serial_clock (o_eeprom_serial_clock),
    .o_eeprom_serial_out   (o_eeprom_serial_out),
    .i_eeprom_serial_in    (i_eeprom_serial_in)
  );
endmodule

//--- sim/eeprom_model.sv
// three-wire serial eeprom model, 64 words of 16 bits
// assumes select frames each read, data msb first after 9 command bits
`timescale 1ns/1ns
module eeprom_model
  import pci_front_pkg::*;
(
  // serial pins as seen from the memory
  input  wire logic i_select,
  input  wire logic i_sclk,
  input  wire logic i_sdo,
  output logic      o_sdi
);
  logic [15:0] mem [0:63];
  logic [8:0]  cmd_q;
  int          cnt_q;

  // shift start, opcode and address; frozen once data starts
  always @(posedge i_sclk or negedge i_select) begin
    if (!i_select) begin
      cnt_q <= 0;
    end else begin
      if (cnt_q < 9) cmd_q <= {cmd_q[7:0], i_sdo};
      cnt_q <= cnt_q + 1;
    end
  end

  // data out on the falling half so it is settled for the rising sample
  always @(negedge i_sclk or negedge i_select) begin
    if (!i_select || cnt_q < 9 || cnt_q > 24) begin
      o_sdi <= ~o_sdi; // toggled outside the data bits, no stale level
    end else if (cmd_q[8:6] == EE_OP_READ) begin
      o_sdi <= mem[cmd_q[5:0]][24-cnt_q];
    end
  end
endmodule

//--- sim/pci_parity_cfg_loader_props.sv
// port assertions for the pci parity and config loader
// assumes binding into the top module, one clock, async low reset
`timescale 1ns/1ns
module pci_parity_cfg_loader_props
  import pci_front_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  input wire logic        i_frame_n,
  input wire logic        i_irdy_n,
  input wire logic        i_idsel,
  input wire logic [31:0] i_ad,
  input wire logic [3:0]  i_cbe_n,
  input wire logic        i_par,
  input wire logic [31:0] o_ad,
  input wire logic        o_par,
  input wire logic        o_par_oe,
  input wire logic        o_trdy_n,
  input wire logic        o_devsel_n,
  input wire logic        o_target_oe,
  input wire logic        o_perr_n,
  input wire logic        o_perr_oe,
  input wire logic        o_serr_oe,
  input wire logic        o_inta_oe,
  input wire logic        i_irq_pending,
  input wire logic        i_irq_enable,
  input wire logic        o_cfg_wr,
  input wire logic [3:0]  o_cfg_wr_idx,
  input wire logic [3:0]  o_cfg_wr_be,
  input wire logic        o_load_done
);
  logic       frame_n_q;
  logic       par_q;
  logic [3:0] cmd_q;
  logic [3:0] idx_q;
  logic [3:0] be_q;
  logic       addr;
  logic       hit;
  logic       apar_bad;
  logic       taken;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  // parity is checked one clock late, so keep last edge's sum
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_n_q <= 1'b1;
      par_q     <= 1'b0;
    end else begin
      frame_n_q <= i_frame_n;
      par_q     <= ^{i_ad, i_cbe_n};
    end
  end
  // command, register index and byte enables of the current transfer
  always_ff @(posedge i_ref_clk) begin
    if (addr) cmd_q <= i_cbe_n;
    if (addr) idx_q <= i_ad[5:2];
    if (taken) be_q <= i_cbe_n;
  end
  assign addr     = frame_n_q && !i_frame_n;
  assign hit      = addr && i_idsel && i_ad[1:0] == 2'h0 &&
                    (i_cbe_n == CMD_CFG_READ || i_cbe_n == CMD_CFG_WRITE);
  assign apar_bad = i_par != par_q;
  assign taken    = o_target_oe && !o_trdy_n && !i_irdy_n;

  sequence s_wr_data;
    taken && cmd_q == CMD_CFG_WRITE;
  endsequence
  sequence s_addr_sel;
    addr && i_idsel ##1 1'b1;
  endsequence

  a_perr_report: assert property (s_wr_data ##1 apar_bad |=>
    (o_perr_oe && !o_perr_n) [*2]) else $error("perr missing");
  a_perr_quiet: assert property (s_wr_data ##1 !apar_bad |=>
    !(o_perr_oe && !o_perr_n) [*2]) else $error("perr without cause");
  a_perr_width: assert property ($fell(o_perr_n) && o_perr_oe |=>
    !o_perr_n) else $error("perr too short");
  a_serr_addr: assert property (s_addr_sel ##0 apar_bad |=>
    o_serr_oe) else $error("serr missing");
  a_serr_clean: assert property (s_addr_sel ##0 !apar_bad |=>
    !o_serr_oe) else $error("serr without cause");
  a_read_par: assert property (o_par_oe |->
    o_par == ^{$past(o_ad), $past(i_cbe_n)}) else $error("par wrong");
  a_claim_hit: assert property (hit |=>
    !o_devsel_n && o_target_oe) else $error("config hit not claimed");
  a_ignore_miss: assert property (addr && !hit |=>
    !o_target_oe [*3]) else $error("miss claimed");
  a_byte_lanes: assert property (o_cfg_wr |->
    o_cfg_wr_be == ~be_q && o_cfg_wr_idx == idx_q)
    else $error("write lanes wrong");
  a_inta_level: assert property (1'b1 |=>
    o_inta_oe == $past(i_irq_pending && i_irq_enable))
    else $error("inta wrong");
  a_no_early_data: assert property (o_target_oe && !o_trdy_n |->
    $past(o_load_done)) else $error("data before load");
endmodule

//--- sim/pci_parity_cfg_loader_tb.sv
// self-checking bench for the pci parity and config loader
// assumes eeprom_model as memory; the bench acts as pci initiator
`timescale 1ns/1ns
module pci_parity_cfg_loader_tb;
  import pci_front_pkg::*;
  logic i_ref_clk = 0, i_rst_n = 0, i_clk_en = 1;
  logic i_frame_n = 1, i_irdy_n = 1, i_idsel = 0, tb_par = 0;
  logic [31:0] tb_ad = '0, o_ad, ad_w, rd;
  logic [3:0] i_cbe_n = '0;
  logic o_ad_oe, o_par, o_par_oe, o_trdy_n, o_stop_n, o_target_oe;
  logic o_perr_n, o_perr_oe, o_serr_oe, o_inta_oe, o_cfg_wr, o_load_done;
  logic pend = 0, ien = 0, use_en = 1, sel, sclk, sdo, sdi, par_w;
  logic [31:0] img [16];
  int failures = 0, total_checks = 0, seed, i, res, perr_n_seen, serr_seen;
  int wr_seen;

  always #20 i_ref_clk = ~i_ref_clk;
  // wire levels: the device wins while it drives
  assign ad_w  = o_ad_oe ? o_ad : tb_ad;
  assign par_w = o_par_oe ? o_par : tb_par;

  pci_parity_cfg_loader dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en), .i_frame_n(i_frame_n), .i_irdy_n(i_irdy_n),
    .i_idsel(i_idsel), .i_ad(ad_w), .i_cbe_n(i_cbe_n), .i_par(par_w),
    .o_ad(o_ad), .o_ad_oe(o_ad_oe), .o_par(o_par), .o_par_oe(o_par_oe),
    .o_trdy_n(o_trdy_n), .o_stop_n(o_stop_n), .o_devsel_n(),
    .o_target_oe(o_target_oe), .o_perr_n(o_perr_n), .o_perr_oe(o_perr_oe),
    .o_serr_oe(o_serr_oe), .o_inta_oe(o_inta_oe), .i_irq_pending(pend),
    .i_irq_enable(ien), .o_cfg_wr(o_cfg_wr), .o_cfg_wr_idx(),
    .o_cfg_wr_data(), .o_cfg_wr_be(), .o_load_done(o_load_done),
    .i_eeprom_use_enable(use_en), .o_eeprom_select(sel),
    .o_eeprom_serial_clock(sclk), .o_eeprom_serial_out(sdo),
    .i_eeprom_serial_in(sdi));
  eeprom_model ee (.i_select(sel), .i_sclk(sclk), .i_sdo(sdo), .o_sdi(sdi));

  // event counters for parity error and write strobes
  always @(posedge i_ref_clk) begin
    if (o_perr_oe && !o_perr_n) perr_n_seen++;
    if (o_serr_oe) serr_seen++;
    if (o_cfg_wr) wr_seen++;
  end

  task automatic chk(input logic [31:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one config transfer, single data phase; res 0 none, 1 data, 2 retry
  task automatic pci(input logic [3:0] cmd, input logic idsel,
      input logic [3:0] idx, be_n, input logic [31:0] wd,
      input logic bad_a, bad_d);
    logic [31:0] a;
    int n;
    a = {26'h0, idx, 2'h0};
    res = 0;
    perr_n_seen = 0;
    serr_seen = 0;
    wr_seen = 0;
    @(negedge i_ref_clk);
    i_frame_n = 0; tb_ad = a; i_cbe_n = cmd; i_idsel = idsel;
    @(negedge i_ref_clk);
    i_frame_n = 1; i_irdy_n = 0; i_cbe_n = be_n; i_idsel = 0;
    tb_par = ^{a, cmd} ^ bad_a;
    tb_ad = cmd[0] ? wd : ~a;
    for (n = 0; n < 6 && res == 0; n++) begin
      if (o_target_oe && !o_trdy_n) res = 1;
      else if (o_target_oe && !o_stop_n) res = 2;
      rd = ad_w;
      if (res == 0) @(negedge i_ref_clk);
    end
    @(negedge i_ref_clk);
    i_irdy_n = 1; tb_ad = ~tb_ad;
    tb_par = cmd[0] ? ^{wd, be_n} ^ bad_d : ~tb_par;
    repeat (6) @(negedge i_ref_clk);
  endtask

  task automatic boot(input logic en, input int lim);
    use_en = en;
    i_rst_n = 0;
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1;
    if (en) pci(CMD_CFG_READ, 1, 0, 0, 0, 0, 0);
    if (en) chk(res, 2, "early read retried");
    for (i = 0; i < lim && !o_load_done; i++) @(negedge i_ref_clk);
    chk(o_load_done, 1, "load done");
  endtask

  task automatic read_all(input string msg);
    for (i = 0; i < 16; i++) begin
      pci(CMD_CFG_READ, 1, i[3:0], 0, 0, 0, 0);
      chk(rd, img[i], msg);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #2400000;
    failures++;
    end_of_test();
  end

  initial begin
    logic [3:0] idx, be;
    logic [31:0] wd;
    seed = 28371;
    for (i = 0; i < 64; i++) ee.mem[i] = 16'($random(seed));
    // pin low: built-in image, memory untouched
    boot(0, 20);
    chk(sel, 0, "no eeprom access");
    img = '{default: DEFAULT_ZERO};
    img[IDX_ID] = DEFAULT_ID;
    img[IDX_CLASS] = DEFAULT_CLASS;
    img[IDX_INT_PIN] = DEFAULT_INTPIN;
    read_all("default image");
    // pin high: words paired low then high into each dword
    boot(1, 30000);
    for (i = 0; i < 16; i++) img[i] = {ee.mem[2*i+1], ee.mem[2*i]};
    read_all("eeprom image");
    // random partial writes, each read back with a config read
    for (int k = 0; k < 8; k++) begin
      idx = 4'($random(seed));
      be = 4'($random(seed));
      wd = $random(seed);
      pci(CMD_CFG_WRITE, 1, idx, be, wd, 0, 0);
      chk(wr_seen, 1, "write strobe");
      for (int b = 0; b < 4; b++) if (!be[b]) img[idx][8*b+:8] = wd[8*b+:8];
      pci(CMD_CFG_READ, 1, idx, 0, 0, 0, 0);
      chk(rd, img[idx], "byte lanes");
    end
    // misses: no select, wrong command, special cycle; all three must leave the image alone
    pci(CMD_CFG_WRITE, 0, 4'h3, 0, 32'h0, 0, 0);
    chk(res, 0, "no idsel ignored");
    pci(CMD_MEM_WRITE, 1, 4'h3, 0, 32'h0, 0, 0);
    chk(res, 0, "mem write ignored");
    pci(CMD_SPECIAL, 1, 4'h3, 0, 32'h0, 0, 1);
    chk(perr_n_seen, 0, "special cycle quiet");
    pci(CMD_CFG_READ, 1, 4'h3, 0, 0, 0, 0);
    chk(rd, img[3], "misses left image");
    pci(CMD_CFG_WRITE, 1, 4'h5, 4'h0, img[5], 0, 1);
    chk(perr_n_seen > 0, 1, "data parity error");
    pci(CMD_CFG_READ, 1, 4'h5, 0, 0, 1, 0);
    chk(serr_seen > 0, 1, "address parity error");
    // interrupt level for every pending and enable pair
    for (i = 0; i < 4; i++) begin
      pend = i[0];
      ien = i[1];
      repeat (2) @(negedge i_ref_clk);
      chk(o_inta_oe, pend & ien, "inta level");
    end
    end_of_test();
  end
endmodule

bind pci_parity_cfg_loader pci_parity_cfg_loader_props u_props (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_frame_n(i_frame_n),
  .i_irdy_n(i_irdy_n), .i_idsel(i_idsel), .i_ad(i_ad), .i_cbe_n(i_cbe_n),
  .i_par(i_par), .o_ad(o_ad), .o_par(o_par), .o_par_oe(o_par_oe),
  .o_trdy_n(o_trdy_n), .o_devsel_n(o_devsel_n), .o_target_oe(o_target_oe),
  .o_perr_n(o_perr_n), .o_perr_oe(o_perr_oe), .o_serr_oe(o_serr_oe),
  .o_inta_oe(o_inta_oe), .i_irq_pending(i_irq_pending),
  .i_irq_enable(i_irq_enable), .o_cfg_wr(o_cfg_wr),
  .o_cfg_wr_idx(o_cfg_wr_idx), .o_cfg_wr_be(o_cfg_wr_be),
  .o_load_done(o_load_done));
